// *** msp_host_model.sv ***
// Two-wire bus host model that only ever pulls the shared wires low.
`timescale 1ns/100ps
module msp_host_model (
    input wire logic linkClk,
    input wire logic sclLine,
    input wire logic sdaLine,
    output logic sclPull,
    output logic sdaPull
);
    int halfLen = 5;

    // Both wires are released at start so the pull-ups hold them idle high.
    initial begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
    end

    task automatic half_wait;
        repeat (halfLen) @(posedge linkClk);
    endtask : half_wait

    // Start or repeated start: data falls while the clock is high.
    task automatic start_cond;
        @(posedge linkClk) sdaPull <= 1'b0;
        half_wait;
        sclPull <= 1'b0;
        half_wait;
        sdaPull <= 1'b1;
        half_wait;
        sclPull <= 1'b1;
        half_wait;
    endtask : start_cond

    // Stop: data rises while the clock is high; the clock then stands still.
    task automatic stop_cond;
        @(posedge linkClk) sdaPull <= 1'b1;
        half_wait;
        sclPull <= 1'b0;
        half_wait;
        sdaPull <= 1'b0;
        half_wait;
    endtask : stop_cond

    // Data changes only while the clock is low and is sampled at the end of the high phase.
    task automatic clock_bit(input logic b, output logic seen);
        @(posedge linkClk) sdaPull <= ~b;
        half_wait;
        sclPull <= 1'b0;
        half_wait;
        seen = sdaLine;
        sclPull <= 1'b1;
        half_wait;
    endtask : clock_bit

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(v[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, v[i]);
        clock_bit(nack, s);
    endtask : recv_byte
endmodule : msp_host_model

// *** msp_mod_ctrl.sv ***
// Management core: power level, readiness flag and interrupt of the module.
`timescale 1ns/100ps
module msp_mod_ctrl #(
    parameter int unsigned INIT_CYCLES = msp_pkg::MSP_INIT_CYCLES,
    parameter int unsigned WAKE_CYCLES = msp_pkg::MSP_WAKE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_pin,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic interrupt_request_n,
    output logic presence_n,
    output logic lowPowerLevel,
    output logic dataNotReady
);
    import msp_pkg::*;

    // ------------------------------------------------------------
    // Link front end
    // ------------------------------------------------------------
    msp_regs_t regs;
    msp_wr_t wrEvent;
    logic wrToggle, rdToggle;
    logic [7:0] rdAddr;

    msp_twi_slave u_link (
        .linkClk(linkClk),
        .sysRst(sys_rst),
        .moduleSelectN(module_select_n),
        .sclIn(sclIn),
        .sclOut(sclOut),
        .sclOe(sclOe),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .regs(regs),
        .wrEvent(wrEvent),
        .wrToggle(wrToggle),
        .rdAddr(rdAddr),
        .rdToggle(rdToggle)
    );

    // ------------------------------------------------------------
    // Crossings into the core clock
    // ------------------------------------------------------------
    logic [3:0] syncMeta, syncMid;
    logic wrSeen, rdSeen;
    logic [7:0] ctrl;

    // Toggles and pins pass two flops; a third copy of each toggle finds its edge.
    always_ff @(posedge ref_clk) begin
        syncMeta <= {wrToggle, rdToggle, module_reset_n, low_power_pin};
        syncMid <= syncMeta;
        wrSeen <= syncMid[3];
        rdSeen <= syncMid[2];
    end

    wire wrPulse = syncMid[3] ^ wrSeen;
    wire rdPulse = syncMid[2] ^ rdSeen;
    wire modResetActive = ~syncMid[1];
    // The low-power pin only limits power; the bit is what software controls.
    wire wantLow = ctrl[MSP_PDOWN_BIT] | syncMid[0];
    // Write data is held by the link until its next byte, long after the toggle lands.
    wire ctrlWrite = wrPulse && (wrEvent.addr == MSP_REG_CTRL);
    wire flagRead = rdPulse && (rdAddr == MSP_REG_FLAGS);

    // ------------------------------------------------------------
    // Control byte and power level
    // ------------------------------------------------------------
    msp_pwr_t pwrState;
    logic [31:0] waitCnt;
    logic readyFlag, notReadyDly;

    wire waitDone = (waitCnt == 32'h00000000);
    wire readyRise = notReadyDly & ~dataNotReady;

    // Software writes only the control byte; other bytes are read-only.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl <= MSP_CTRL_RST;
        end else if (ctrlWrite) begin
            ctrl <= wrEvent.data;
        end
    end

    // Power-down takes effect at once; waking waits for the settle count.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || modResetActive) begin
            pwrState <= PWR_WAKE;
            waitCnt <= INIT_CYCLES - 32'h1;
        end else begin
            case (pwrState)
                PWR_FULL: begin
                    if (wantLow) begin
                        pwrState <= PWR_LOW;
                    end
                end
                PWR_LOW: begin
                    if (!wantLow) begin
                        pwrState <= PWR_WAKE;
                        waitCnt <= WAKE_CYCLES - 32'h1;
                    end
                end
                PWR_WAKE: begin
                    if (wantLow) begin
                        pwrState <= PWR_LOW;
                    end else if (waitDone) begin
                        pwrState <= PWR_FULL;
                    end else begin
                        waitCnt <= waitCnt - 32'h1;
                    end
                end
                default: begin
                    pwrState <= PWR_WAKE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Readiness, flag and interrupt
    // ------------------------------------------------------------
    // A new readiness edge in the same cycle as a clearing read keeps the flag set.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            notReadyDly <= 1'b1;
            readyFlag <= 1'b0;
            interrupt_request_n <= 1'b1;
            lowPowerLevel <= 1'b0;
            dataNotReady <= 1'b1;
        end else begin
            dataNotReady <= (pwrState != PWR_FULL);
            notReadyDly <= dataNotReady;
            lowPowerLevel <= (pwrState == PWR_LOW);
            if (readyRise) begin
                readyFlag <= 1'b1;
            end else if (flagRead) begin
                readyFlag <= 1'b0;
            end
            interrupt_request_n <= ~readyFlag;
        end
    end

    assign presence_n = 1'b0;

    // Bytes offered to the link for reading.
    always_comb begin
        regs.ctrl = ctrl;
        regs.flags = MSP_FLAGS_RST;
        regs.flags[MSP_READY_FLAG_BIT] = readyFlag;
        regs.status = MSP_STATUS_RST;
        regs.status[MSP_NOT_READY_BIT] = dataNotReady;
    end

endmodule : msp_mod_ctrl

// *** msp_mod_ctrl_monitor.sv ***
// Concurrent checks on the ports of the module select and power control block.
`timescale 1ns/100ps
module msp_mod_ctrl_monitor #(
    parameter int unsigned INIT_CYCLES = 200,
    parameter int unsigned WAKE_CYCLES = 100
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_pin,
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic interrupt_request_n,
    input wire logic presence_n,
    input wire logic lowPowerLevel,
    input wire logic dataNotReady
);
    int unsigned waitCnt;

    // Counts cycles spent not ready outside low power; the power-up wait is the longest case.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !dataNotReady || lowPowerLevel || !module_reset_n) waitCnt <= 0;
        else waitCnt <= waitCnt + 1;
    end

    // ------------------------------------------------------------
    // Readiness and power level
    // ------------------------------------------------------------
    sequence s_ready_edge;
        $fell(dataNotReady);
    endsequence
    sequence s_irq_low;
        ##[1:4] !interrupt_request_n;
    endsequence

    a_reset_outputs: assert property (@(posedge ref_clk) sys_rst |=>
        interrupt_request_n && dataNotReady && !lowPowerLevel) else $error("reset state wrong");
    a_ready_irq: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_ready_edge |-> s_irq_low) else $error("interrupt missing after ready");
    a_ready_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
        waitCnt <= INIT_CYCLES + 8) else $error("not ready for too long");
    a_pdown_notready: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(lowPowerLevel) |-> ##[0:2] dataNotReady) else $error("not-ready flag missed");
    a_pin_lowpower: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(low_power_pin) |-> ##[1:6] lowPowerLevel) else $error("low power not entered");
    a_pins_passive: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !sclOe && !sdaOut && !presence_n) else $error("wire driven high or clock held");

    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    a_deselect_release: assert property (@(posedge linkClk) disable iff (sys_rst)
        $rose(module_select_n) |-> ##[1:5] !sdaOe) else $error("data not released");
    a_deselect_quiet: assert property (@(posedge linkClk) disable iff (sys_rst)
        module_select_n [*6] |-> !sdaOe) else $error("answer while deselected");
    a_data_clock_low: assert property (@(posedge linkClk) disable iff (sys_rst)
        $changed(sdaOe) && !module_select_n |-> !sclIn) else $error("data moved with clock high");
endmodule : msp_mod_ctrl_monitor

bind msp_mod_ctrl msp_mod_ctrl_monitor #(.INIT_CYCLES(INIT_CYCLES), .WAKE_CYCLES(WAKE_CYCLES))
    msp_mod_ctrl_monitor_i (.*);

// *** msp_mod_ctrl_tb_top.sv ***
// Self-checking bench of the module select and power control block.
`timescale 1ns/100ps
module msp_mod_ctrl_tb_top;
    import msp_pkg::*;
    localparam int unsigned INIT = 200;
    localparam int unsigned WAKE = 100;
    logic ref_clk = 1'b0;
    logic linkClk = 1'b0;
    logic sys_rst = 1'b1;
    logic module_select_n = 1'b1;
    logic module_reset_n = 1'b1;
    logic low_power_pin = 1'b0;
    logic sclOut, sclOe, sdaOut, sdaOe, hostScl, hostSda;
    logic interrupt_request_n, presence_n, lowPowerLevel, dataNotReady, ack;
    logic [7:0] v, r;
    int err_total = 0;
    int checked = 0;
    int seed = 32'he059;
    int n;
    wire logic sclLine = ~(hostScl | (sclOe & ~sclOut));
    wire logic sdaLine = ~(hostSda | (sdaOe & ~sdaOut));

    initial forever #2 ref_clk = ~ref_clk;
    initial begin
        #1.3;
        forever #3 linkClk = ~linkClk;
    end

    msp_mod_ctrl #(.INIT_CYCLES(INIT), .WAKE_CYCLES(WAKE)) msp_mod_ctrl_i (.ref_clk, .sys_rst,
        .linkClk, .module_select_n, .module_reset_n, .low_power_pin, .sclIn(sclLine), .sclOut,
        .sclOe, .sdaIn(sdaLine), .sdaOut, .sdaOe, .interrupt_request_n, .presence_n,
        .lowPowerLevel, .dataNotReady);
    msp_host_model msp_host_model_i (.linkClk, .sclLine, .sdaLine, .sclPull(hostScl),
        .sdaPull(hostSda));

    // ------------------------------------------------------------
    // Expectations, comparisons and bus cycles
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_low_bit(input logic b);
        return {7'h00, b};
    endfunction : exp_low_bit

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp_byte

    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] val);
        logic a2;
        msp_host_model_i.start_cond;
        msp_host_model_i.send_byte({dev, 1'b0}, ack);
        if (ack) msp_host_model_i.send_byte(ptr, a2);
        if (ack) msp_host_model_i.send_byte(val, a2);
        msp_host_model_i.stop_cond;
    endtask : wr_reg

    // Pointer set, repeated start, one byte read and refused with a final no-acknowledge.
    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] val);
        logic a2;
        msp_host_model_i.start_cond;
        msp_host_model_i.send_byte({MSP_DEV_ADDR, 1'b0}, a2);
        msp_host_model_i.send_byte(ptr, a2);
        msp_host_model_i.start_cond;
        msp_host_model_i.send_byte({MSP_DEV_ADDR, 1'b1}, a2);
        msp_host_model_i.recv_byte(1'b1, val);
        msp_host_model_i.stop_cond;
    endtask : rd_reg

    task automatic wait_dnr(input logic lvl, input int lim);
        n = 0;
        while (dataNotReady !== lvl && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_dnr

    task automatic tally_and_finish;
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        cmp_byte("reset outputs", 8'h0c, {4'h0, interrupt_request_n, dataNotReady,
            lowPowerLevel, sdaOe});
        sys_rst <= 1'b0;
        wait_dnr(1'b0, INIT + 20);
        cmp_bit("power-up window", 1'b1, n >= INIT - 4 && n <= INIT + 6);
        repeat (4) @(posedge ref_clk);
        cmp_bit("interrupt at ready", 1'b0, interrupt_request_n);
        wr_reg(MSP_DEV_ADDR, MSP_REG_CTRL, 8'h02);
        cmp_bit("ack while deselected", 1'b0, ack);
        @(posedge ref_clk) module_select_n <= 1'b0;
        repeat (8) @(posedge linkClk);
        wr_reg(MSP_DEV_ADDR ^ (7'h01 << ($unsigned($random(seed)) % 7)), MSP_REG_CTRL, 8'h02);
        cmp_bit("ack for foreign address", 1'b0, ack);
        rd_reg(MSP_REG_FLAGS, v);
        cmp_byte("ready flag", exp_low_bit(1'b1), v);
        rd_reg(MSP_REG_STATUS, v);
        cmp_byte("status", exp_low_bit(1'b0), v);
        cmp_bit("interrupt after read", 1'b1, interrupt_request_n);
        rd_reg(MSP_REG_FLAGS, v);
        cmp_byte("flag after read", exp_low_bit(1'b0), v);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            if (i == 0) v[MSP_PDOWN_BIT] = 1'b1;
            msp_host_model_i.halfLen = (i == 1) ? 12 : 5;
            wr_reg(MSP_DEV_ADDR, MSP_REG_CTRL, v);
            cmp_bit("ack for own address", 1'b1, ack);
            repeat (20) @(posedge ref_clk);
            cmp_bit("low power level", v[MSP_PDOWN_BIT], lowPowerLevel);
            rd_reg(MSP_REG_CTRL, r);
            cmp_byte("control readback", v, r);
            rd_reg(MSP_REG_STATUS, r);
            cmp_byte("status in power step", exp_low_bit(v[MSP_PDOWN_BIT]), r);
            wr_reg(MSP_DEV_ADDR, MSP_REG_CTRL, 8'h00);
            wait_dnr(1'b0, WAKE + 20);
            cmp_bit("wake window", 1'b1, n <= WAKE + 8);
            repeat (4) @(posedge ref_clk);
            cmp_bit("interrupt after wake", !v[MSP_PDOWN_BIT], interrupt_request_n);
            rd_reg(MSP_REG_FLAGS, r);
            cmp_byte("flag after wake", exp_low_bit(v[MSP_PDOWN_BIT]), r);
        end
        @(posedge ref_clk) low_power_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        cmp_bit("pin low power", 1'b1, lowPowerLevel);
        low_power_pin <= 1'b0;
        wait_dnr(1'b0, WAKE + 20);
        cmp_bit("pin wake window", 1'b1, n <= WAKE + 8);
        module_reset_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        module_reset_n <= 1'b1;
        wait_dnr(1'b0, INIT + 20);
        cmp_bit("reset pin window", 1'b1, n <= INIT + 8);
        @(posedge ref_clk) module_select_n <= 1'b1;
        repeat (8) @(posedge linkClk);
        wr_reg(MSP_DEV_ADDR, MSP_REG_CTRL, 8'h02);
        cmp_bit("ack after deselect", 1'b0, ack);
        tally_and_finish;
    end

    // Cuts a hang short well beyond the expected length of the run.
    initial begin
        #400000;
        err_total++;
        tally_and_finish;
    end
endmodule : msp_mod_ctrl_tb_top

// *** msp_pkg.sv ***
// Package of constants, types and state codes for the module select and power control block.
package msp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned MSP_CLK_KHZ = 250000;
    localparam int unsigned MSP_T_INIT_MS = 2000;
    localparam int unsigned MSP_T_WAKE_MS = 300;
    localparam int unsigned MSP_INIT_CYCLES = MSP_T_INIT_MS * MSP_CLK_KHZ;
    localparam int unsigned MSP_WAKE_CYCLES = MSP_T_WAKE_MS * MSP_CLK_KHZ;

    // ------------------------------------------------------------
    // Two-wire address and byte map
    // ------------------------------------------------------------
    localparam logic [6:0] MSP_DEV_ADDR = 7'h50;
    localparam logic [7:0] MSP_REG_STATUS = 8'h02;
    localparam logic [7:0] MSP_REG_FLAGS = 8'h03;
    localparam logic [7:0] MSP_REG_CTRL = 8'h5d;
    localparam int unsigned MSP_NOT_READY_BIT = 0;
    localparam int unsigned MSP_READY_FLAG_BIT = 0;
    localparam int unsigned MSP_PDOWN_BIT = 1;
    localparam logic [7:0] MSP_STATUS_RST = 8'h01;
    localparam logic [7:0] MSP_FLAGS_RST = 8'h00;
    localparam logic [7:0] MSP_CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] flags;
        logic [7:0] status;
    } msp_regs_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } msp_wr_t;

    typedef enum logic [2:0] {
        PWR_FULL = 3'b001,
        PWR_LOW = 3'b010,
        PWR_WAKE = 3'b100
    } msp_pwr_t;

    typedef enum logic [5:0] {
        LNK_IDLE = 6'b000001,
        LNK_ADDR = 6'b000010,
        LNK_ACKA = 6'b000100,
        LNK_WRITE = 6'b001000,
        LNK_ACKW = 6'b010000,
        LNK_READ = 6'b100000
    } msp_lnk_t;

endpackage : msp_pkg

// *** msp_twi_slave.sv ***
// Two-wire serial slave front end running on the link clock.
`timescale 1ns/100ps
module msp_twi_slave (
    input wire logic linkClk,
    input wire logic sysRst,
    input wire logic moduleSelectN,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input msp_pkg::msp_regs_t regs,
    output msp_pkg::msp_wr_t wrEvent,
    output logic wrToggle,
    output logic [7:0] rdAddr,
    output logic rdToggle
);
    import msp_pkg::*;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic rstMeta, rstLink;
    logic [3:0] pinMeta, pinSync;
    msp_regs_t regMeta, regSync;
    logic sclDly, sdaDly;

    // Reset, pins and core bytes each pass two flops; core bytes change slowly.
    always_ff @(posedge linkClk) begin
        rstMeta <= sysRst;
        rstLink <= rstMeta;
        pinMeta <= {moduleSelectN, sclIn, sdaIn, 1'b0};
        pinSync <= pinMeta;
        regMeta <= regs;
        regSync <= regMeta;
        sclDly <= pinSync[2];
        sdaDly <= pinSync[1];
    end

    wire selected = ~pinSync[3];
    wire scl = pinSync[2];
    wire sda = pinSync[1];
    wire sclRise = scl & ~sclDly;
    wire sclFall = ~scl & sclDly;
    wire startSeen = scl & sclDly & sdaDly & ~sda;
    wire stopSeen = scl & sclDly & ~sdaDly & sda;

    // Byte selection for reads; unmapped bytes read as zero.
    function automatic logic [7:0] readByte(input msp_regs_t r, input logic [7:0] a);
        readByte = (a == MSP_REG_STATUS) ? r.status :
                   (a == MSP_REG_FLAGS) ? r.flags :
                   (a == MSP_REG_CTRL) ? r.ctrl : 8'h00;
    endfunction : readByte

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    msp_lnk_t state;
    logic [7:0] shift, txByte, ptr;
    logic [3:0] bitCnt;
    logic rw, ptrPhase, ackPhase, sdaDrive;

    // Byte at the current pointer; a named wire because a call result cannot be bit-selected.
    wire [7:0] curByte = readByte(regSync, ptr);

    // The slave never stretches the clock, so the clock pin is only read.
    assign sclOut = 1'b0;
    assign sclOe = 1'b0;
    assign sdaOut = 1'b0;
    assign sdaOe = sdaDrive;

    // Bits are sampled on clock rise and driven after clock fall.
    always_ff @(posedge linkClk) begin
        if (rstLink) begin
            state <= LNK_IDLE;
            shift <= 8'h00;
            txByte <= 8'h00;
            ptr <= 8'h00;
            bitCnt <= 4'h0;
            rw <= 1'b0;
            ptrPhase <= 1'b0;
            ackPhase <= 1'b0;
            sdaDrive <= 1'b0;
            wrEvent <= '0;
            wrToggle <= 1'b0;
            rdAddr <= 8'h00;
            rdToggle <= 1'b0;
        end else if (!selected || stopSeen) begin
            state <= LNK_IDLE;
            sdaDrive <= 1'b0;
        end else if (startSeen) begin
            state <= LNK_ADDR;
            bitCnt <= 4'h0;
            sdaDrive <= 1'b0;
        end else begin
            case (state)
                LNK_ADDR: begin
                    if (sclRise) begin
                        shift <= {shift[6:0], sda};
                        bitCnt <= bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == 4'h8) begin
                        if (shift[7:1] == MSP_DEV_ADDR) begin
                            rw <= shift[0];
                            sdaDrive <= 1'b1;
                            state <= LNK_ACKA;
                        end else begin
                            state <= LNK_IDLE;
                        end
                    end
                end
                LNK_ACKA: begin
                    if (sclFall) begin
                        bitCnt <= 4'h0;
                        if (rw) begin
                            txByte <= curByte;
                            sdaDrive <= ~curByte[7];
                            ackPhase <= 1'b0;
                            state <= LNK_READ;
                        end else begin
                            sdaDrive <= 1'b0;
                            ptrPhase <= 1'b1;
                            state <= LNK_WRITE;
                        end
                    end
                end
                LNK_WRITE: begin
                    if (sclRise) begin
                        shift <= {shift[6:0], sda};
                        bitCnt <= bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == 4'h8) begin
                        sdaDrive <= 1'b1;
                        state <= LNK_ACKW;
                        if (ptrPhase) begin
                            ptr <= shift;
                            ptrPhase <= 1'b0;
                        end else begin
                            wrEvent <= '{addr: ptr, data: shift};
                            wrToggle <= ~wrToggle;
                            ptr <= ptr + 8'h01;
                        end
                    end
                end
                LNK_ACKW: begin
                    if (sclFall) begin
                        sdaDrive <= 1'b0;
                        bitCnt <= 4'h0;
                        state <= LNK_WRITE;
                    end
                end
                LNK_READ: begin
                    if (sclRise) begin
                        if (ackPhase && sda) begin
                            state <= LNK_IDLE; // Host refused the next byte.
                        end
                        bitCnt <= bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (ackPhase) begin
                            txByte <= curByte;
                            sdaDrive <= ~curByte[7];
                            bitCnt <= 4'h0;
                            ackPhase <= 1'b0;
                        end else if (bitCnt == 4'h8) begin
                            sdaDrive <= 1'b0;
                            ackPhase <= 1'b1;
                            rdAddr <= ptr;
                            rdToggle <= ~rdToggle;
                            ptr <= ptr + 8'h01;
                        end else begin
                            txByte <= {txByte[6:0], 1'b0};
                            sdaDrive <= ~txByte[6];
                        end
                    end
                end
                default: begin
                    sdaDrive <= 1'b0;
                end
            endcase
        end
    end

endmodule : msp_twi_slave
